// ===== design/ddr_fifo_pkg.sv
// constants shared by the dual-clock fifo port logic
// assumes one core clock samples every outside clock as a level
package ddr_fifo_pkg;
   localparam int DATA_W = 40;
   localparam int DEPTH = 32;
   localparam int PTR_W = 5;
   localparam int CNT_W = 6;
   localparam int OFS_W = 5;
   localparam int OFS_BITS = 10;
   localparam logic [OFS_W-1:0] PAE_OFS_RST = 5'h04;
   localparam logic [OFS_W-1:0] PAF_OFS_RST = 5'h04;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
   localparam logic [DATA_W-1:0] DATA_ZERO = 40'h00_0000_0000;
   localparam logic [3:0] OFS_IDX_ZERO = 4'h0;
   localparam logic [3:0] OFS_IDX_LAST = 4'h9;
   localparam int FLAG_STAGES = 2;
   localparam int FALL_EDGES = 3;
   localparam real SCLK_MAX_MHZ = 10.0;
   typedef enum logic [1:0] {
      FT_EMPTY = 2'b00,
      FT_WAIT1 = 2'b01,
      FT_WAIT2 = 2'b10,
      FT_VALID = 2'b11
   } fall_state_t;
endpackage

// ===== design/dual_clock_ddr_fifo_ports.sv
// dual-clock fifo port control, offset serial interface and output enable
// assumes wr/rd/serial clocks are slow pins sampled by core_clk at 250 MHz
`timescale 1ns/1ps
// What this block does
// - sdr write: store one word per rising wclk with enable and select low
// - ddr write: store on both wclk edges, qualified at rising edge
// - stopped wclk freezes full and almost-full flags
// - accepted words go to consecutive locations independent of reads
// - write enable high at rising wclk stores nothing on that edge or the next fall
// - standard mode: full low when full, released two wclk after read
// - fall-through: input-ready high when full, low two wclk after read
// - writes ignored while memory full
// - sdr read: one word per rising rclk with enable and select low
// - ddr read: words on both rclk edges, qualified at rising edge
// - stopped rclk freezes empty and almost-empty flags
// - standard mode: rising rclk with enable and select low, not empty loads next output word
// - read enable high at rising rclk holds output register through the next fall, except the fall-through first-word load on the third rclk rise
// - standard: every word requested, empty low at end, reads ignored
// - fall-through: first word shown on third rclk rise after write
// - fall-through: true read after last word sets output-ready high
// - serial enable low shifts one offset bit per sclk rise
// - serial enable high leaves offsets unchanged
// - readout enable low shifts offset bits out per sclk rise
// - each new readout starts at first offset bit
// - output enable high floats outputs, low drives output register if chip select was low at last rclk rise
// - during reset only output enable controls float, not chip select
// - fall-through select sampled during master reset
// - data-rate selects latched during master reset
// - fall-through used only with single data rate
// - full and input-ready pass two register stages on wclk rises
module dual_clock_ddr_fifo_ports
   import ddr_fifo_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic master_reset_n,
   input wire logic partial_reset_n,
   input wire logic fall_through_sel,
   input wire logic wr_single_rate_sel,
   input wire logic rd_single_rate_sel,
   input wire logic wr_clk,
   input wire logic wr_en_n,
   input wire logic wr_chip_select_n,
   input wire logic [ddr_fifo_pkg::DATA_W-1:0] wr_data,
   input wire logic rd_clk,
   input wire logic rd_en_n,
   input wire logic rd_chip_select_n,
   input wire logic out_enable_n,
   output logic [ddr_fifo_pkg::DATA_W-1:0] read_data_out,
   output logic read_data_oe,
   output logic full_n,
   output logic almost_full_n,
   output logic empty_n,
   output logic almost_empty_n,
   input wire logic ser_clk,
   input wire logic ser_in,
   input wire logic offset_load_enable_n,
   input wire logic offset_readout_enable_n,
   output logic ser_out
);
   import ddr_fifo_pkg::*;

   // three-stage samplers; change counts when stages two and three agree
   logic [2:0] wclk_s_ff, rclk_s_ff, sclk_s_ff, mrs_s_ff, prs_s_ff;
   logic [2:0] wen_s_ff, wcs_s_ff, ren_s_ff, rcs_s_ff, sen_s_ff, offset_readout_enable_n_s_ff, si_s_ff;
   logic [DATA_W-1:0] wdat_s1_ff, wdat_s2_ff, wdat_s3_ff;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wclk_s_ff <= 3'h0;
         rclk_s_ff <= 3'h0;
         sclk_s_ff <= 3'h0;
         mrs_s_ff <= 3'h0;
         prs_s_ff <= 3'h7;
         wen_s_ff <= 3'h7;
         wcs_s_ff <= 3'h7;
         ren_s_ff <= 3'h7;
         rcs_s_ff <= 3'h7;
         sen_s_ff <= 3'h7;
         offset_readout_enable_n_s_ff <= 3'h7;
         si_s_ff <= 3'h0;
         wdat_s1_ff <= DATA_ZERO;
         wdat_s2_ff <= DATA_ZERO;
         wdat_s3_ff <= DATA_ZERO;
      end else if (clk_en) begin
         wclk_s_ff <= {wclk_s_ff[1:0], wr_clk};
         rclk_s_ff <= {rclk_s_ff[1:0], rd_clk};
         sclk_s_ff <= {sclk_s_ff[1:0], ser_clk};
         mrs_s_ff <= {mrs_s_ff[1:0], master_reset_n};
         prs_s_ff <= {prs_s_ff[1:0], partial_reset_n};
         wen_s_ff <= {wen_s_ff[1:0], wr_en_n};
         wcs_s_ff <= {wcs_s_ff[1:0], wr_chip_select_n};
         ren_s_ff <= {ren_s_ff[1:0], rd_en_n};
         rcs_s_ff <= {rcs_s_ff[1:0], rd_chip_select_n};
         sen_s_ff <= {sen_s_ff[1:0], offset_load_enable_n};
         offset_readout_enable_n_s_ff <= {offset_readout_enable_n_s_ff[1:0], offset_readout_enable_n};
         si_s_ff <= {si_s_ff[1:0], ser_in};
         wdat_s1_ff <= wr_data;
         wdat_s2_ff <= wdat_s1_ff;
         wdat_s3_ff <= wdat_s2_ff;
      end
   end

   // edges: stage two and three agreeing after a change of stage three
   logic wclk_lvl_ff, rclk_lvl_ff, sclk_lvl_ff;
   wire wclk_agree = (wclk_s_ff[1] == wclk_s_ff[2]);
   wire rclk_agree = (rclk_s_ff[1] == rclk_s_ff[2]);
   wire sclk_agree = (sclk_s_ff[1] == sclk_s_ff[2]);
   wire wclk_rise = wclk_agree && wclk_s_ff[2] && !wclk_lvl_ff;
   wire wclk_fall = wclk_agree && !wclk_s_ff[2] && wclk_lvl_ff;
   wire rclk_rise = rclk_agree && rclk_s_ff[2] && !rclk_lvl_ff;
   wire rclk_fall = rclk_agree && !rclk_s_ff[2] && rclk_lvl_ff;
   wire sclk_rise = sclk_agree && sclk_s_ff[2] && !sclk_lvl_ff;
   wire in_master_rst = !mrs_s_ff[2];
   wire in_reset = !mrs_s_ff[2] || !prs_s_ff[2];

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wclk_lvl_ff <= 1'b0;
         rclk_lvl_ff <= 1'b0;
         sclk_lvl_ff <= 1'b0;
      end else if (clk_en) begin
         if (wclk_agree) wclk_lvl_ff <= wclk_s_ff[2];
         if (rclk_agree) rclk_lvl_ff <= rclk_s_ff[2];
         if (sclk_agree) sclk_lvl_ff <= sclk_s_ff[2];
      end
   end

   // static configuration caught while master reset stands
   logic fall_through_sel_ff, wddr_ff, rddr_ff;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fall_through_sel_ff <= 1'b0;
         wddr_ff <= 1'b0;
         rddr_ff <= 1'b0;
      end else if (clk_en && in_master_rst) begin
         fall_through_sel_ff <= fall_through_sel;
         wddr_ff <= wr_single_rate_sel && !fall_through_sel;
         rddr_ff <= rd_single_rate_sel && !fall_through_sel;
      end
   end

   // write side; qualify captured at rising edge, reused at falling edge
   logic wr_qual_ff;
   logic [CNT_W-1:0] fill_level;
   wire mem_full = (fill_level == CNT_FULL);
   wire wr_qual_now = !wen_s_ff[2] && !wcs_s_ff[2];
   wire wr_rise_go = wclk_rise && wr_qual_now;
   wire wr_fall_go = wclk_fall && wddr_ff && wr_qual_ff;
   wire wr_push = (wr_rise_go || wr_fall_go) && !mem_full && !in_reset;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) wr_qual_ff <= 1'b0;
      else if (clk_en && wclk_rise) wr_qual_ff <= wr_qual_now;
   end

   // storage and pointers, shared in core_clk since both clocks are sampled
   logic [DATA_W-1:0] head_word;
   logic [DATA_W-1:0] out_reg_ff;
   fall_state_t ft_ff, nxt_ft;
   logic rd_qual_ff;

   wire mem_empty = (fill_level == CNT_ZERO);
   wire rd_qual_now = !ren_s_ff[2] && !rcs_s_ff[2];
   wire rd_edge_go = (rclk_rise && rd_qual_now)
      || (rclk_fall && rddr_ff && rd_qual_ff);
   wire ft_load = fall_through_sel_ff && rclk_rise && (ft_ff == FT_WAIT2) && !mem_empty;
   wire ft_true_read = fall_through_sel_ff && (ft_ff == FT_VALID) && rclk_rise && rd_qual_now;
   wire std_pop = !fall_through_sel_ff && rd_edge_go && !mem_empty;
   wire ft_pop = ft_true_read && !mem_empty;
   wire rd_pop = (std_pop || ft_pop || ft_load) && !in_reset;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) rd_qual_ff <= 1'b0;
      else if (clk_en && rclk_rise) rd_qual_ff <= rd_qual_now;
   end

   // pushes and pops are already gated by full, empty and reset
   word_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(DEPTH)
   ) i_word_fifo (
      .clk(core_clk),
      .rst_n(reset_n),
      .clk_en(clk_en),
      .flush(in_reset),
      .in_valid(wr_push),
      .in_ready(),
      .in_data(wdat_s3_ff),
      .out_valid(),
      .out_ready(rd_pop),
      .out_data(head_word),
      .level(fill_level)
   );

   // output register: loads on pop, clears during reset, holds otherwise
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) out_reg_ff <= DATA_ZERO;
      else if (clk_en) begin
         if (in_reset) out_reg_ff <= DATA_ZERO;
         else if (rd_pop) out_reg_ff <= head_word;
      end
   end

   // fall-through pipeline: word appears on third rclk rise after write
   always_comb begin
      nxt_ft = ft_ff;
      case (ft_ff)
         FT_EMPTY: if (rclk_rise && !mem_empty) nxt_ft = FT_WAIT1;
         FT_WAIT1: if (rclk_rise) nxt_ft = FT_WAIT2;
         FT_WAIT2: if (ft_load) nxt_ft = FT_VALID;
         FT_VALID: if (ft_true_read && mem_empty) nxt_ft = FT_EMPTY;
         default: nxt_ft = FT_EMPTY;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) ft_ff <= FT_EMPTY;
      else if (clk_en) ft_ff <= in_reset ? FT_EMPTY : nxt_ft;
   end

   // flags: full/ready through two stages on wclk rises, empty on rclk rises
   logic [FLAG_STAGES-1:0] full_pipe_ff;
   logic paf_ff, empty_ff, pae_ff;
   logic [OFS_BITS-1:0] ofs_ff;
   wire [OFS_W-1:0] pae_ofs = ofs_ff[OFS_W-1:0];
   wire [OFS_W-1:0] paf_ofs = ofs_ff[OFS_BITS-1:OFS_W];
   wire full_now = mem_full;
   wire paf_now = (fill_level >= (CNT_FULL - {1'b0, paf_ofs}));
   wire pae_now = (fill_level <= {1'b0, pae_ofs});
   wire empty_now = fall_through_sel_ff ? (nxt_ft != FT_VALID) : mem_empty;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         full_pipe_ff <= '0;
         paf_ff <= 1'b0;
         empty_ff <= 1'b1;
         pae_ff <= 1'b1;
      end else if (clk_en) begin
         if (in_reset) begin
            full_pipe_ff <= '0;
            paf_ff <= 1'b0;
            empty_ff <= 1'b1;
            pae_ff <= 1'b1;
         end else begin
            if (wclk_rise) begin
               full_pipe_ff <= {full_pipe_ff[0], full_now};
               paf_ff <= paf_now;
            end
            if (rclk_rise) begin
               empty_ff <= empty_now;
               pae_ff <= pae_now;
            end
         end
      end
   end

   // standard: full low active; fall-through: ready high when full
   wire full_seen = full_pipe_ff[FLAG_STAGES-1];
   assign full_n = fall_through_sel_ff ? full_seen : !full_seen;
   assign almost_full_n = !paf_ff;
   assign empty_n = fall_through_sel_ff ? empty_ff : !empty_ff;
   assign almost_empty_n = !pae_ff;

   // offset shift register and readout
   logic [3:0] rd_idx_ff;
   logic offset_readout_enable_n_prev_ff, ser_out_ff;
   wire load_go = sclk_rise && !sen_s_ff[2];
   wire readout_go = sclk_rise && !offset_readout_enable_n_s_ff[2];
   wire readout_start = !offset_readout_enable_n_s_ff[2] && offset_readout_enable_n_prev_ff;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ofs_ff <= {PAF_OFS_RST, PAE_OFS_RST};
         rd_idx_ff <= OFS_IDX_ZERO;
         offset_readout_enable_n_prev_ff <= 1'b1;
         ser_out_ff <= 1'b0;
      end else if (clk_en) begin
         offset_readout_enable_n_prev_ff <= offset_readout_enable_n_s_ff[2];
         if (in_master_rst) ofs_ff <= {PAF_OFS_RST, PAE_OFS_RST};
         else if (load_go) ofs_ff <= {ofs_ff[OFS_BITS-2:0], si_s_ff[2]};
         if (readout_start) rd_idx_ff <= OFS_IDX_ZERO;
         else if (readout_go) begin
            ser_out_ff <= ofs_ff[rd_idx_ff];
            rd_idx_ff <= (rd_idx_ff == OFS_IDX_LAST) ? OFS_IDX_ZERO : rd_idx_ff + 1'b1;
         end
      end
   end
   assign ser_out = ser_out_ff;

   // output drive: chip select registered on rclk, ignored during reset
   logic rcs_drive_ff;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) rcs_drive_ff <= 1'b0;
      else if (clk_en && rclk_rise && !in_reset) rcs_drive_ff <= !rcs_s_ff[2];
   end
   assign read_data_out = out_reg_ff;
   assign read_data_oe = !out_enable_n && (in_reset || rcs_drive_ff);

   // checks
   sequence s_wr_rise_ok;
      wclk_rise && wr_qual_now && !mem_full && !in_reset;
   endsequence

   a_write_stores: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en and s_wr_rise_ok) |=>
      i_word_fifo.wptr_ff == $past(i_word_fifo.wptr_ff) + 1'b1)
      else $error("qualified write not stored");
   a_no_write_disabled: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && wen_s_ff[2] && !wclk_fall |-> !wr_push)
      else $error("write while enable high");
   a_no_overflow: assert property (@(posedge core_clk) disable iff (!reset_n)
      mem_full |-> !wr_push)
      else $error("write while full");
   a_full_frozen: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && !wclk_rise && !in_reset |=> $stable(full_pipe_ff))
      else $error("full flag moved without wclk");
   a_empty_frozen: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && !rclk_rise && !in_reset |=> $stable(empty_ff))
      else $error("empty flag moved without rclk");
   a_out_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && !rd_pop && !in_reset |=> $stable(out_reg_ff))
      else $error("output register changed without read");
   a_no_underflow: assert property (@(posedge core_clk) disable iff (!reset_n)
      mem_empty |-> !rd_pop)
      else $error("read while empty");
   a_offset_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && sen_s_ff[2] && !in_master_rst |=> $stable(ofs_ff))
      else $error("offsets changed with load disabled");
   a_oe_float: assert property (@(posedge core_clk) disable iff (!reset_n)
      out_enable_n |-> !read_data_oe)
      else $error("output driven with enable high");
   a_reset_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
      in_reset && !out_enable_n |-> read_data_oe)
      else $error("chip select floated bus in reset");
endmodule

// word buffer: flop storage, index pointers, fill level
module word_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] LVL_FULL = (PW + 1)'(DEPTH);
   localparam logic [PW:0] LVL_ZERO = '0;
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wptr_ff, rptr_ff;
   logic [PW:0] level_ff;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (level_ff != LVL_FULL);
   assign out_valid = (level_ff != LVL_ZERO);
   assign out_data = mem_ff[rptr_ff];
   assign level = level_ff;

   always_ff @(posedge clk) begin
      if (clk_en && push) mem_ff[wptr_ff] <= in_data;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         level_ff <= LVL_ZERO;
      end else if (clk_en) begin
         if (flush) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            level_ff <= LVL_ZERO;
         end else begin
            if (push) wptr_ff <= wptr_ff + 1'b1;
            if (pop) rptr_ff <= rptr_ff + 1'b1;
            if (push && !pop) level_ff <= level_ff + 1'b1;
            else if (pop && !push) level_ff <= level_ff - 1'b1;
         end
      end
   end
endmodule

// ===== test/fifo_far_side.sv
// writer and reader logic on the far side of the fifo ports
// assumes core_clk from the bench; link clocks rest low between cycles
`timescale 1ns/1ps
module fifo_far_side
   import ddr_fifo_pkg::*;
(
   input wire logic core_clk,
   input wire logic [ddr_fifo_pkg::DATA_W-1:0] read_data_out,
   output logic wr_clk,
   output logic wr_en_n,
   output logic wr_chip_select_n,
   output logic [ddr_fifo_pkg::DATA_W-1:0] wr_data,
   output logic rd_clk,
   output logic rd_en_n,
   output logic rd_chip_select_n
);
   initial begin
      wr_clk = 1'b0;
      wr_en_n = 1'b1;
      wr_chip_select_n = 1'b1;
      wr_data = DATA_ZERO;
      rd_clk = 1'b0;
      rd_en_n = 1'b1;
      rd_chip_select_n = 1'b1;
   end
   // one 125 ns write period; d1 rides the falling edge
   task automatic wr_cycle(input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
                           input logic en_n, input logic cs_n);
      @(negedge core_clk);
      wr_en_n = en_n;
      wr_chip_select_n = cs_n;
      wr_data = d0;
      #31.25 wr_clk = 1'b1;
      #31.25 wr_data = d1;
      #31.25 wr_clk = 1'b0;
      #31.25 wr_en_n = 1'b1;
      wr_chip_select_n = 1'b1;
      wr_data = ~d1; // released bus shows no stale word
   endtask
   // one read period; q0 after the rise, q1 after the fall
   task automatic rd_cycle(input logic en_n, input logic cs_n,
                           output logic [DATA_W-1:0] q0, output logic [DATA_W-1:0] q1);
      @(negedge core_clk);
      rd_en_n = en_n; // one request per period, covering both words in ddr
      rd_chip_select_n = cs_n;
      #31.25 rd_clk = 1'b1;
      #31.25 q0 = read_data_out;
      #31.25 rd_clk = 1'b0;
      #31.25 q1 = read_data_out;
      rd_en_n = 1'b1;
      rd_chip_select_n = 1'b1;
   endtask
endmodule

// ===== test/tb_top.sv
// self-checking bench for the dual-clock fifo port logic
// assumes the far-side model drives the write and read ports
`timescale 1ns/1ps
module tb_top;
   import ddr_fifo_pkg::*;
   logic core_clk, reset_n, clk_en, master_reset_n, partial_reset_n, fall_through_sel;
   logic wr_single_rate_sel, rd_single_rate_sel, out_enable_n, ser_clk, ser_in;
   logic offset_load_enable_n, offset_readout_enable_n;
   logic wr_clk, wr_en_n, wr_chip_select_n, rd_clk, rd_en_n, rd_chip_select_n;
   logic [DATA_W-1:0] wr_data, read_data_out, q0, q1;
   logic read_data_oe, full_n, almost_full_n, empty_n, almost_empty_n, ser_out;
   logic [OFS_BITS-1:0] ov;
   logic [OFS_BITS-1:0] pat = 10'h2B5;
   int failures = 0;
   int compares = 0;
   dual_clock_ddr_fifo_ports i_dual_clock_ddr_fifo_ports (.core_clk(core_clk),
      .reset_n(reset_n), .clk_en(clk_en), .master_reset_n(master_reset_n),
      .partial_reset_n(partial_reset_n), .fall_through_sel(fall_through_sel),
      .wr_single_rate_sel(wr_single_rate_sel), .rd_single_rate_sel(rd_single_rate_sel),
      .wr_clk(wr_clk), .wr_en_n(wr_en_n), .wr_chip_select_n(wr_chip_select_n),
      .wr_data(wr_data), .rd_clk(rd_clk), .rd_en_n(rd_en_n),
      .rd_chip_select_n(rd_chip_select_n), .out_enable_n(out_enable_n),
      .read_data_out(read_data_out), .read_data_oe(read_data_oe), .full_n(full_n),
      .almost_full_n(almost_full_n), .empty_n(empty_n), .almost_empty_n(almost_empty_n),
      .ser_clk(ser_clk), .ser_in(ser_in), .offset_load_enable_n(offset_load_enable_n),
      .offset_readout_enable_n(offset_readout_enable_n), .ser_out(ser_out));
   fifo_far_side i_fifo_far_side (.core_clk(core_clk), .read_data_out(read_data_out),
      .wr_clk(wr_clk), .wr_en_n(wr_en_n), .wr_chip_select_n(wr_chip_select_n),
      .wr_data(wr_data), .rd_clk(rd_clk), .rd_en_n(rd_en_n),
      .rd_chip_select_n(rd_chip_select_n));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic conclude;
      if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_bit(input string nm, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s exp %b got %b", nm, exp, got);
      end
   endtask
   task automatic chk_word(input string nm, input logic [DATA_W-1:0] exp,
                           input logic [DATA_W-1:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   function automatic logic [DATA_W-1:0] wd(input int i);
      return 40'hC3_5A00_0000 + 40'(i);
   endfunction
   task automatic mreset(input logic ft, input logic wddr, input logic rddr);
      @(negedge core_clk);
      fall_through_sel = ft;
      wr_single_rate_sel = wddr;
      rd_single_rate_sel = rddr;
      master_reset_n = 1'b0;
      repeat (6) @(negedge core_clk);
      master_reset_n = 1'b1;
      repeat (6) @(negedge core_clk);
   endtask
   // serial period 240 ns, below the 10 MHz ceiling
   task automatic ser_cyc(input logic ld_n, input logic ro_n, input logic b);
      @(negedge core_clk);
      offset_load_enable_n = ld_n;
      offset_readout_enable_n = ro_n;
      ser_in = b;
      #120 ser_clk = 1'b1;
      #120 ser_clk = 1'b0;
      ser_in = ~b;
   endtask
   task automatic rd_ofs(input int n, output logic [OFS_BITS-1:0] v);
      v = '0;
      for (int i = 0; i < n; i++) begin
         ser_cyc(1'b1, 1'b0, 1'b0);
         v[i] = ser_out;
      end
      ser_cyc(1'b1, 1'b1, 1'b0);
   endtask
   task automatic rd_n(input int n, input logic en_n, input logic cs_n);
      repeat (n) i_fifo_far_side.rd_cycle(en_n, cs_n, q0, q1);
   endtask
   task automatic wr_idle(input int n);
      repeat (n) i_fifo_far_side.wr_cycle(DATA_ZERO, DATA_ZERO, 1'b1, 1'b0);
   endtask
   initial begin
      repeat (50000) @(posedge core_clk);
      failures++;
      conclude();
   end
   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      master_reset_n = 1'b1;
      partial_reset_n = 1'b1;
      fall_through_sel = 1'b0;
      wr_single_rate_sel = 1'b0;
      rd_single_rate_sel = 1'b0;
      out_enable_n = 1'b0;
      ser_clk = 1'b0;
      ser_in = 1'b0;
      offset_load_enable_n = 1'b1;
      offset_readout_enable_n = 1'b1;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      reset_n = 1'b1;
      chk_bit("empty_n", 1'b0, empty_n);
      chk_bit("full_n", 1'b1, full_n);
      chk_bit("almost_empty_n", 1'b0, almost_empty_n);
      mreset(1'b0, 1'b0, 1'b0);
      rd_ofs(OFS_BITS, ov);
      chk_word("offsets", 40'({PAF_OFS_RST, PAE_OFS_RST}), 40'(ov));
      rd_ofs(3, ov);
      rd_ofs(OFS_BITS, ov);
      chk_word("offsets", 40'({PAF_OFS_RST, PAE_OFS_RST}), 40'(ov));
      for (int i = OFS_BITS - 1; i >= 0; i--) ser_cyc(1'b0, 1'b1, pat[i]);
      for (int i = 0; i < OFS_BITS; i++) ser_cyc(1'b1, 1'b1, ~pat[i]);
      rd_ofs(OFS_BITS, ov);
      chk_word("offsets", 40'(pat), 40'(ov));
      i_fifo_far_side.wr_cycle(wd(1), wd(1), 1'b1, 1'b0);
      i_fifo_far_side.wr_cycle(wd(2), wd(2), 1'b0, 1'b1);
      rd_n(2, 1'b1, 1'b0);
      chk_bit("empty_n", 1'b0, empty_n);
      for (int i = 0; i < 3; i++) i_fifo_far_side.wr_cycle(wd(i), DATA_ZERO, 1'b0, 1'b0);
      chk_bit("empty_n", 1'b0, empty_n);
      rd_n(2, 1'b1, 1'b0);
      chk_bit("empty_n", 1'b1, empty_n);
      rd_n(1, 1'b0, 1'b1);
      chk_word("read_data_out", DATA_ZERO, q1);
      for (int i = 0; i < 4; i++) begin
         rd_n(1, 1'b0, 1'b0);
         chk_word("read_data_out", wd(i < 3 ? i : 2), q1);
      end
      chk_bit("empty_n", 1'b0, empty_n);
      for (int i = 0; i < 33; i++) i_fifo_far_side.wr_cycle(wd(i + 8), DATA_ZERO, 1'b0, 1'b0);
      wr_idle(2);
      chk_bit("full_n", 1'b0, full_n);
      chk_bit("almost_full_n", 1'b0, almost_full_n);
      rd_n(2, 1'b1, 1'b0);
      rd_n(1, 1'b0, 1'b0);
      chk_bit("full_n", 1'b0, full_n);
      wr_idle(2);
      chk_bit("full_n", 1'b1, full_n);
      for (int i = 1; i < 33; i++) begin
         rd_n(1, 1'b0, 1'b0);
         chk_word("read_data_out", wd((i < 32 ? i : 31) + 8), q1);
      end
      @(negedge core_clk);
      partial_reset_n = 1'b0;
      repeat (6) @(negedge core_clk);
      chk_bit("read_data_oe", 1'b1, read_data_oe);
      chk_word("read_data_out", DATA_ZERO, read_data_out);
      out_enable_n = 1'b1;
      repeat (2) @(negedge core_clk);
      chk_bit("read_data_oe", 1'b0, read_data_oe);
      out_enable_n = 1'b0;
      partial_reset_n = 1'b1;
      repeat (6) @(negedge core_clk);
      rd_n(1, 1'b1, 1'b0);
      chk_bit("read_data_oe", 1'b1, read_data_oe);
      rd_n(1, 1'b1, 1'b1);
      chk_bit("read_data_oe", 1'b0, read_data_oe);
      chk_bit("empty_n", 1'b0, empty_n);
      rd_ofs(OFS_BITS, ov);
      chk_word("offsets", 40'(pat), 40'(ov));
      mreset(1'b0, 1'b1, 1'b1);
      i_fifo_far_side.wr_cycle(wd(50), wd(51), 1'b0, 1'b0);
      i_fifo_far_side.wr_cycle(wd(52), wd(53), 1'b0, 1'b0);
      rd_n(2, 1'b1, 1'b0);
      for (int i = 50; i < 54; i += 2) begin
         rd_n(1, 1'b0, 1'b0);
         chk_word("read_data_out", wd(i), q0);
         chk_word("read_data_out", wd(i + 1), q1);
      end
      mreset(1'b1, 1'b0, 1'b0);
      chk_bit("full_n", 1'b0, full_n);
      i_fifo_far_side.wr_cycle(wd(60), DATA_ZERO, 1'b0, 1'b0);
      rd_n(2, 1'b1, 1'b1);
      chk_word("read_data_out", DATA_ZERO, q1);
      chk_bit("empty_n", 1'b1, empty_n);
      rd_n(1, 1'b1, 1'b1);
      chk_word("read_data_out", wd(60), q1);
      chk_bit("empty_n", 1'b0, empty_n);
      for (int i = 0; i < 2; i++) begin
         rd_n(1, 1'b0, 1'b0);
         chk_word("read_data_out", wd(60), q1);
         chk_bit("empty_n", 1'b1, empty_n);
      end
      conclude();
   end
endmodule
